/* hdl/qdac_code_bank.sv */
// Purpose: Register bank holding four converter code words and the first setup register
// Assumes: Single clock; registers reached over classic Wishbone, byte lane 0
// Notes:   Unmapped words acknowledge, read zero and ignore writes
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "qdac_defines.svh"

module qdac_code_bank
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Wishbone slave
    input  wire qdac_pkg::qdac_wb_req_t wb_req_i,
    output qdac_pkg::qdac_wb_rsp_t      wb_rsp_o,
    // Converter codes
    output logic [`QDAC_CODE_W-1:0]     analog_out_chan_a,
    output logic [`QDAC_CODE_W-1:0]     analog_out_chan_b,
    output logic [`QDAC_CODE_W-1:0]     analog_out_chan_c,
    output logic [`QDAC_CODE_W-1:0]     analog_out_chan_d,
    // Converter control
    output logic                        standby_request_bit,
    output logic [`QDAC_REG_W-2:0]      setup_fields_o
);
    import qdac_pkg::*;

    localparam logic [`QDAC_IDX_W-1:0] LOW_IDX [`QDAC_CHANNELS] = '{
        `QDAC_IDX_A_LOW,
        `QDAC_IDX_B_LOW,
        `QDAC_IDX_C_LOW,
        `QDAC_IDX_D_LOW
    };
    localparam logic [`QDAC_IDX_W-1:0] HIGH_IDX [`QDAC_CHANNELS] = '{
        `QDAC_IDX_A_HIGH,
        `QDAC_IDX_B_HIGH,
        `QDAC_IDX_C_HIGH,
        `QDAC_IDX_D_HIGH
    };
    localparam logic [`QDAC_REG_W-1:0] LOW_MASK = `QDAC_LOW_MASK;

    qdac_bank_st_t                  st;
    qdac_bank_st_t                  next_st;
    logic                           access;
    logic                           wr;
    logic [`QDAC_IDX_W-1:0]         idx;
    logic                           ack;
    logic [`QDAC_CODE_W-1:0]        codes [`QDAC_CHANNELS];

    qdac_wb_slave u_slave
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .req_i    (wb_req_i),
        .access_o (access),
        .idx_o    (idx),
        .ack_o    (ack)
    );

    // Only byte lane 0 carries register data; other lanes are ignored
    assign wr = access & wb_req_i.we & wb_req_i.sel[0];

    always_comb
    begin
        next_st = st;
        if (access)
        begin
            // Unmapped words answer zero; a write answers the old content
            next_st.rd = '0;
            for (int c = 0; c < `QDAC_CHANNELS; c++)
            begin
                if (idx == LOW_IDX[c])
                begin
                    if (wr)
                        next_st.low[c] = wb_req_i.dat[`QDAC_REG_W-1:0] & LOW_MASK;
                    next_st.rd = {24'h0, st.low[c]};
                end
                if (idx == HIGH_IDX[c])
                begin
                    if (wr)
                        next_st.high[c] = wb_req_i.dat[`QDAC_REG_W-1:0];
                    next_st.rd = {24'h0, st.high[c]};
                end
            end
            if (idx == `QDAC_IDX_SETUP)
            begin
                if (wr)
                    next_st.setup = wb_req_i.dat[`QDAC_REG_W-1:0];
                next_st.rd = {24'h0, st.setup};
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st       <= '0;
            st.low   <= {`QDAC_CHANNELS{`QDAC_REG_RST}};
            st.high  <= {`QDAC_CHANNELS{`QDAC_REG_RST}};
            st.setup <= `QDAC_REG_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Code words keep their value in standby so the output returns unchanged
    generate
        for (genvar g = 0; g < `QDAC_CHANNELS; g++)
        begin : g_chan
            qdac_code_join u_join
            (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .high_i (st.high[g]),
                .low_i  (st.low[g]),
                .code_o (codes[g])
            );
        end
    endgenerate

    assign analog_out_chan_a   = codes[0];
    assign analog_out_chan_b   = codes[1];
    assign analog_out_chan_c   = codes[2];
    assign analog_out_chan_d   = codes[3];
    assign standby_request_bit = st.setup[`QDAC_STANDBY_BIT];
    assign setup_fields_o      = st.setup[`QDAC_STANDBY_BIT-1:0];

    assign wb_rsp_o.ack = ack;
    assign wb_rsp_o.dat = st.rd;

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    ack_single_pulse_a: assert property (
        ack |=> !ack
    ) else $error("ack held for more than one cycle");

    a_high_write_a: assert property (
        wr && idx == `QDAC_IDX_A_HIGH
        |=> st.high[0] == $past(wb_req_i.dat[7:0]) ##1
            analog_out_chan_a[11:4] == $past(wb_req_i.dat[7:0], 2)
    ) else $error("channel A upper write did not reach the code");

    a_high_read_a: assert property (
        access && !wb_req_i.we && idx == `QDAC_IDX_A_HIGH
        |=> ack && wb_rsp_o.dat == {24'h0, $past(st.high[0])}
    ) else $error("channel A upper readback wrong");

    b_code_join_a: assert property (
        $past(!rst_i)
        |-> analog_out_chan_b == {$past(st.high[1]), $past(st.low[1][7:4])}
    ) else $error("channel B code not joined from its registers");

    c_code_join_a: assert property (
        wr && idx == `QDAC_IDX_C_LOW
        |=> ##1 analog_out_chan_c[3:0] == $past(wb_req_i.dat[7:4], 2)
    ) else $error("channel C low bits did not reach the code");

    d_code_join_a: assert property (
        wr && idx == `QDAC_IDX_D_HIGH ##1 !(wr && idx == `QDAC_IDX_D_HIGH)
        |=> analog_out_chan_d[11:4] == st.high[3]
    ) else $error("channel D upper bits did not reach the code");

    low_field_mask_a: assert property (
        ((st.low[0] | st.low[1] | st.low[2] | st.low[3]) & ~LOW_MASK) == 8'h00
    ) else $error("unused low register bits were stored");

    high_bit_order_a: assert property (
        $past(!rst_i)
        |-> analog_out_chan_a[11] == $past(st.high[0][7])
            && analog_out_chan_a[4] == $past(st.high[0][0])
    ) else $error("upper register bit order wrong");

    reset_clears_a: assert property (
        $past(rst_i)
        |-> st.low == '0 && st.high == '0 && st.setup == 8'h00
            ##1 analog_out_chan_a == 12'h000 && analog_out_chan_d == 12'h000
    ) else $error("registers not cleared by reset");

    setup_write_a: assert property (
        wr && idx == `QDAC_IDX_SETUP
        |=> st.setup == $past(wb_req_i.dat[7:0])
            && setup_fields_o == $past(wb_req_i.dat[6:0])
    ) else $error("setup register write lost");

    standby_enter_a: assert property (
        wr && idx == `QDAC_IDX_SETUP && wb_req_i.dat[7]
        |=> standby_request_bit
    ) else $error("standby not entered");

    standby_bus_alive_a: assert property (
        standby_request_bit && access |=> ack
    ) else $error("bus stopped answering in standby");

    low_read_zero_a: assert property (
        access && !wb_req_i.we && idx == `QDAC_IDX_B_LOW
        |=> wb_rsp_o.dat[3:0] == 4'h0 && wb_rsp_o.dat[31:8] == 24'h0
    ) else $error("unused low bits did not read as zero");

    unmapped_read_a: assert property (
        access && !wb_req_i.we && idx > `QDAC_IDX_SETUP
        |=> ack && wb_rsp_o.dat == 32'h0
    ) else $error("unmapped word did not read zero");

endmodule

/* hdl/qdac_code_join.sv */
// Purpose: Joins one channel's upper and lower code registers into a code word
// Assumes: Unused low positions are already zero
// Notes:   The word is registered so the converter sees clean edges
`timescale 1ns/1ps
`include "qdac_defines.svh"

module qdac_code_join
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Register contents
    input  wire logic [`QDAC_REG_W-1:0]  high_i,
    input  wire logic [`QDAC_REG_W-1:0]  low_i,
    // Joined code
    output logic [`QDAC_CODE_W-1:0]      code_o
);
    import qdac_pkg::*;

    qdac_join_st_t st;
    qdac_join_st_t next_st;

    assign code_o = st.code;

    always_comb
    begin
        next_st      = st;
        next_st.code = {high_i, low_i[`QDAC_REG_W-1 -: `QDAC_LOW_BITS]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end

endmodule

/* hdl/qdac_defines.svh */
// Purpose: Offsets, field positions, reset values and sizes of the code bank
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   The ten-bit variant sets QDAC_LOW_BITS to 2 and QDAC_LOW_MASK to 8'hc0
`ifndef QDAC_DEFINES_SVH
`define QDAC_DEFINES_SVH

`define QDAC_IDX_W        6
`define QDAC_IDX_A_LOW    6'h10
`define QDAC_IDX_A_HIGH   6'h11
`define QDAC_IDX_B_LOW    6'h12
`define QDAC_IDX_B_HIGH   6'h13
`define QDAC_IDX_C_LOW    6'h14
`define QDAC_IDX_C_HIGH   6'h15
`define QDAC_IDX_D_LOW    6'h16
`define QDAC_IDX_D_HIGH   6'h17
`define QDAC_IDX_SETUP    6'h18

`define QDAC_ADR_W        8
`define QDAC_DAT_W        32
`define QDAC_SEL_W        4
`define QDAC_REG_W        8
`define QDAC_CHANNELS     4
`define QDAC_LOW_BITS     4
`define QDAC_LOW_MASK     8'hf0
`define QDAC_CODE_W       12
`define QDAC_STANDBY_BIT  7
`define QDAC_REG_RST      8'h00

`endif

/* hdl/qdac_pkg.sv */
// Purpose: Types shared by the converter code bank
// Assumes: Constants come from qdac_defines.svh
// Notes:   Bus structs carry classic Wishbone signals unchanged
`include "qdac_defines.svh"

package qdac_pkg;

    typedef struct packed {
        logic                     cyc;
        logic                     stb;
        logic                     we;
        logic [`QDAC_ADR_W-1:0]   adr;
        logic [`QDAC_SEL_W-1:0]   sel;
        logic [`QDAC_DAT_W-1:0]   dat;
    } qdac_wb_req_t;

    typedef struct packed {
        logic                     ack;
        logic [`QDAC_DAT_W-1:0]   dat;
    } qdac_wb_rsp_t;

    typedef struct packed {
        logic                     ack;
    } qdac_slv_st_t;

    typedef struct packed {
        logic [`QDAC_CODE_W-1:0]  code;
    } qdac_join_st_t;

    typedef struct packed {
        logic [`QDAC_CHANNELS-1:0][`QDAC_REG_W-1:0] low;
        logic [`QDAC_CHANNELS-1:0][`QDAC_REG_W-1:0] high;
        logic [`QDAC_REG_W-1:0]                     setup;
        logic [`QDAC_DAT_W-1:0]                     rd;
    } qdac_bank_st_t;

endpackage

/* hdl/qdac_wb_slave.sv */
// Purpose: Classic Wishbone handshake for the code bank
// Assumes: Master holds the request until it samples ack
// Notes:   Ack comes one cycle after the request and lasts one cycle
`timescale 1ns/1ps
`include "qdac_defines.svh"

module qdac_wb_slave
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Bus request
    input  wire qdac_pkg::qdac_wb_req_t req_i,
    // Decoded access
    output logic                        access_o,
    output logic [`QDAC_IDX_W-1:0]      idx_o,
    output logic                        ack_o
);
    import qdac_pkg::*;

    qdac_slv_st_t st;
    qdac_slv_st_t next_st;

    // The held ack blocks a second access from the same request
    assign access_o = req_i.cyc & req_i.stb & ~st.ack;
    assign idx_o    = req_i.adr[`QDAC_ADR_W-1:2];
    assign ack_o    = st.ack;

    always_comb
    begin
        next_st     = st;
        next_st.ack = access_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end

endmodule

/* verif/qdac_code_bank_tb.sv */
// Purpose: Self-checking bench for the converter code bank
// Assumes: Ack comes one cycle after a request; one idle cycle between bus cycles
// Notes:   Random traffic from a fixed-seed shift register, corner cases mixed in
`timescale 1ns/1ps
`include "qdac_defines.svh"

module qdac_code_bank_tb;
    import qdac_pkg::*;

    logic                       clk_i;
    logic                       rst_i;
    qdac_wb_req_t               wb_req;
    qdac_wb_rsp_t               wb_rsp;
    logic [`QDAC_CODE_W-1:0]    code_out [`QDAC_CHANNELS];
    logic                       standby;
    logic [`QDAC_REG_W-2:0]     fields;
    logic [`QDAC_REG_W-1:0]     low_m [`QDAC_CHANNELS];
    logic [`QDAC_REG_W-1:0]     high_m [`QDAC_CHANNELS];
    logic [`QDAC_REG_W-1:0]     setup_m;
    logic [15:0]                lfsr;
    logic [31:0]                rd;
    logic [31:0]                wd;
    logic [5:0]                 idx;
    int                         fails;
    int                         samples_checked;

    qdac_code_bank dut
    (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .wb_req_i            (wb_req),
        .wb_rsp_o            (wb_rsp),
        .analog_out_chan_a   (code_out[0]),
        .analog_out_chan_b   (code_out[1]),
        .analog_out_chan_c   (code_out[2]),
        .analog_out_chan_d   (code_out[3]),
        .standby_request_bit (standby),
        .setup_fields_o      (fields)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] exp_rd(input logic [5:0] i);
        if (i >= `QDAC_IDX_A_LOW && i <= `QDAC_IDX_D_HIGH)
            return {24'h0, i[0] ? high_m[i[2:1]] : low_m[i[2:1]]};
        else if (i == `QDAC_IDX_SETUP)
            return {24'h0, setup_m};
        return 32'h0;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic model_clear();
        for (int c = 0; c < `QDAC_CHANNELS; c++)
        begin
            low_m[c] = `QDAC_REG_RST;
            high_m[c] = `QDAC_REG_RST;
        end
        setup_m = `QDAC_REG_RST;
    endtask

    // Unused low positions are masked so later reads expect zero there
    task automatic model_wr(input logic [5:0] i, input logic [3:0] s, input logic [7:0] d);
        if (!s[0])
            return;
        if (i >= `QDAC_IDX_A_LOW && i <= `QDAC_IDX_D_HIGH && i[0])
            high_m[i[2:1]] = d;
        else if (i >= `QDAC_IDX_A_LOW && i <= `QDAC_IDX_D_HIGH)
            low_m[i[2:1]] = d & `QDAC_LOW_MASK;
        else if (i == `QDAC_IDX_SETUP)
            setup_m = d;
    endtask

    // Request is held until ack is sampled; read data taken at that same edge
    task automatic bus(input logic w, input logic [5:0] i, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {i, 2'b00}, sel: s, dat: d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_rsp.ack !== 1'b1 && n < 20);
        rd = wb_rsp.dat;
        wb_req <= '0;
        if (wb_rsp.ack !== 1'b1)
        begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_out(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Outputs lag storage by one edge, so look half a cycle after the ack edge
    task automatic check_outs();
        @(negedge clk_i);
        for (int c = 0; c < `QDAC_CHANNELS; c++)
            check_out(code_out[c], {high_m[c], low_m[c][7:4]});
        check_out({4'h0, standby, fields}, {4'h0, setup_m});
    endtask

    task automatic read_all();
        for (int i = 6'h10; i <= 6'h19; i++)
        begin
            bus(1'b0, 6'(i), 4'hf, 32'h0);
            check_rd(rd, exp_rd(6'(i)));
        end
    endtask

    initial
    begin
        rst_i = 1'b1;
        wb_req = '0;
        fails = 0;
        samples_checked = 0;
        lfsr = 16'h001f;
        model_clear();
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        check_outs();
        read_all();
        $display("test reset_values done");
        for (int i = 6'h10; i <= 6'h18; i++)
        begin
            bus(1'b1, 6'(i), 4'h1, 32'hffff_ffff);
            model_wr(6'(i), 4'h1, 8'hff);
            check_outs();
        end
        read_all();
        $display("test all_ones done");
        bus(1'b1, `QDAC_IDX_SETUP, 4'h1, 32'h80);
        model_wr(`QDAC_IDX_SETUP, 4'h1, 8'h80);
        bus(1'b1, `QDAC_IDX_B_HIGH, 4'h1, 32'h5a);
        model_wr(`QDAC_IDX_B_HIGH, 4'h1, 8'h5a);
        check_outs();
        read_all();
        bus(1'b1, `QDAC_IDX_SETUP, 4'h1, 32'h0);
        model_wr(`QDAC_IDX_SETUP, 4'h1, 8'h0);
        check_outs();
        $display("test standby done");
        repeat (80)
        begin
            lfsr = lfsr_next(lfsr);
            idx = (lfsr[15:12] == 4'hf) ? 6'h3f : 6'h10 + 6'(lfsr[3:0] % 4'd10);
            wd = {lfsr, lfsr_next(lfsr)};
            bus(1'b1, idx, lfsr[7:4], wd);
            model_wr(idx, lfsr[7:4], wd[7:0]);
            check_outs();
            bus(1'b0, idx, 4'hf, 32'h0);
            check_rd(rd, exp_rd(idx));
        end
        $display("test random_traffic done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        model_clear();
        check_outs();
        read_all();
        $display("test second_reset done");
        end_of_test();
    end
endmodule
